/* File: common/energy_cal_pkg.sv */
// Package holding constants and widths for the active energy gain/offset block
package energy_cal_pkg;
  localparam int CLK_HZ         = 10_000_000;  // System clock rate
  localparam int QUARTER_DIV    = 4;           // Accumulation tick every 4 clocks
  localparam int PERIOD_DIV     = 8;           // Line period counts 8-clock units
  localparam int PWR_W          = 24;          // Active power sample width
  localparam int GAIN_W         = 12;          // Gain word width
  localparam int GAIN_SHIFT     = 12;          // Gain is (4096 + gain) / 4096
  localparam int OFS_W          = 16;          // Offset word width
  localparam int OFS_FRAC       = 8;           // Fractional offset bits
  localparam int ENERGY_W       = 24;          // Visible energy register width
  localparam int FINE_FRAC      = 33;          // Fine units per energy LSB, as a power of two
  localparam int FINE_W         = ENERGY_W + FINE_FRAC;
  localparam int DIV_W          = 8;           // Energy divider width
  localparam int CFR_W          = 12;          // Pulse rate numerator/denominator width
  localparam int HALF_CYCLE_COUNT_W      = 16;          // Half cycle count width
  localparam int PERIOD_W       = 16;          // Line period width
  localparam int CF_PULSE_NS    = 10000;       // Calibration pulse high time
  localparam int CF_PULSE_CYC   = (CF_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CF_PULSE_W     = 8;           // Width of pulse timer
  localparam logic [DIV_W-1:0] DIV_MIN = 8'h01;  // Divider value 0 acts as 1
endpackage : energy_cal_pkg

/* File: common/timebase_if.sv */
// Interface carrying the accumulation tick and line period between modules
`timescale 1ns/1ps
interface timebase_if;
  import energy_cal_pkg::*;
  logic                tick_quarter;  // One-cycle pulse every QUARTER_DIV clocks
  logic                half_edge;     // One-cycle pulse per half line cycle
  logic [PERIOD_W-1:0] line_period;   // Last period in 8-clock units
  modport src  (output tick_quarter, output line_period, input half_edge);
  modport sink (input tick_quarter, input line_period, output half_edge);
endinterface : timebase_if

/* File: hdl/line_timebase.sv */
// Quarter-rate tick divider and line period counter
`timescale 1ns/1ps
module line_timebase
  import energy_cal_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   rst,
  timebase_if.src     tb
);
  typedef struct packed {
    logic [2:0]          pre;      // Free running divider
    logic                tick;     // Quarter-rate pulse
    logic [PERIOD_W-1:0] per_cnt;  // Running period count
    logic [PERIOD_W-1:0] period;   // Latched period
  } tb_state_t;

  tb_state_t s;       // Registered state
  tb_state_t next_s;  // Next state

  assign tb.tick_quarter = s.tick;
  assign tb.line_period  = s.period;

  // Divider and period measurement
  always_comb begin
    next_s      = s;
    next_s.pre  = s.pre + 3'h1;
    next_s.tick = (s.pre[1:0] == 2'(QUARTER_DIV - 1));
    if (tb.half_edge) begin
      // Period spans one half cycle; measured from each half-cycle edge to the next
      next_s.period  = s.per_cnt;
      next_s.per_cnt = '0;
    end else if (s.pre == 3'(PERIOD_DIV - 1) && s.per_cnt != '1) begin
      // Saturate rather than wrap when no line is present
      next_s.per_cnt = s.per_cnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_quarter_rate;
    tb.tick_quarter |=> !tb.tick_quarter [*3] ##1 tb.tick_quarter;
  endproperty
  a_quarter_rate: assert property (p_quarter_rate) else $error("quarter tick spacing wrong");

  property p_period_latch;
    tb.half_edge |=> tb.line_period == $past(s.per_cnt);
  endproperty
  a_period_latch: assert property (p_period_latch) else $error("period not latched at edge");
endmodule : line_timebase

/* File: hdl/active_energy_cal.sv */
// Active energy gain/offset correction, divider, calibration pulse and line-cycle accumulation
`timescale 1ns/1ps
module active_energy_cal
  import energy_cal_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic signed [PWR_W-1:0]     active_power,
  input  wire logic                        half_cycle_edge,
  input  wire logic signed [GAIN_W-1:0]    active_power_gain,
  input  wire logic signed [OFS_W-1:0]     active_power_offset,
  input  wire logic [DIV_W-1:0]            energy_divider,
  input  wire logic [CFR_W-1:0]            pulse_rate_numerator,
  input  wire logic [CFR_W-1:0]            pulse_rate_denominator,
  input  wire logic [HALF_CYCLE_COUNT_W-1:0]        half_cycle_count,
  input  wire logic                        line_mode,
  input  wire logic                        line_irq_enable,
  input  wire logic                        status_clear,
  output logic signed [ENERGY_W-1:0]       active_energy_accum,
  output logic signed [ENERGY_W-1:0]       line_accum_active_energy,
  output logic [PERIOD_W-1:0]              line_period,
  output logic                             line_done_status,
  output logic                             calibration_pulse_out,
  output logic                             irq_oe_n
);
  ////////////////////////////////////////////////////////////////////////////
  typedef logic signed [FINE_W-1:0] fine_t;  // Energy in 2^-33 LSB units

  typedef struct packed {
    fine_t                       fine;      // Fine energy accumulator
    logic signed [DIV_W+1:0]     div_cnt;   // Divider prescaler
    logic signed [ENERGY_W-1:0]  energy;    // Visible energy
    logic [CFR_W:0]              cf_cnt;    // Pulse rate accumulator
    logic [CF_PULSE_W-1:0]       cf_timer;  // Pulse high time left
    logic                        cf_out;    // Pulse output
    logic                        mode_q;    // Line mode last cycle
    logic [HALF_CYCLE_COUNT_W-1:0]        half_cnt;  // Half cycles in window
    logic signed [ENERGY_W-1:0]  window;    // Energy in current window
    logic signed [ENERGY_W-1:0]  line_e;    // Latched window energy
    logic                        status;    // Window done flag
    logic                        irq_oe_n;  // Interrupt pin enable, low drives
  } cal_state_t;

  cal_state_t s;       // Registered state
  cal_state_t next_s;  // Next state

  timebase_if tb ();   // Tick and period carrier

  ////////////////////////////////////////////////////////////////////////////
  // Gained power plus offset, in fine units
  function automatic fine_t tick_delta(input logic signed [PWR_W-1:0] p,
                                       input logic signed [GAIN_W-1:0] g,
                                       input logic signed [OFS_W-1:0] o);
    logic signed [GAIN_W+1:0]       factor;
    logic signed [PWR_W+GAIN_W+1:0] prod;
    factor = (GAIN_W+2)'(1 <<< GAIN_SHIFT) + (GAIN_W+2)'(g);
    prod   = (PWR_W+GAIN_W+2)'(p) * (PWR_W+GAIN_W+2)'(factor);
    // Power unit is 256 offset units, so the offset keeps 8 fraction bits
    return (FINE_W'(prod >>> GAIN_SHIFT) <<< OFS_FRAC) + FINE_W'(o);
  endfunction : tick_delta

  // Whole energy LSB carry between two fine values
  function automatic logic signed [1:0] lsb_carry(input fine_t a, input fine_t b);
    logic signed [ENERGY_W-1:0] d;
    d = b[FINE_W-1:FINE_FRAC] - a[FINE_W-1:FINE_FRAC];
    return 2'(d);
  endfunction : lsb_carry

  fine_t                      delta;    // This tick's fine increment
  logic signed [1:0]          carry;    // Whole LSB step this cycle
  logic signed [DIV_W+1:0]    div_eff;  // Divider with zero as one
  logic signed [DIV_W+1:0]    div_sum;  // Prescaler after carry
  logic signed [1:0]          e_step;   // Visible energy step
  logic [CFR_W:0]             cf_sum;   // Pulse accumulator after carry
  logic                       win_end;  // Window completes this cycle

  ////////////////////////////////////////////////////////////////////////////
  line_timebase u_timebase (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tb      (tb)
  );

  assign tb.half_edge               = half_cycle_edge;
  assign active_energy_accum        = s.energy;
  assign line_accum_active_energy   = s.line_e;
  assign line_period                = tb.line_period;
  assign line_done_status           = s.status;
  assign calibration_pulse_out      = s.cf_out;
  assign irq_oe_n                   = s.irq_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s  = s;
    delta   = tick_delta(active_power, active_power_gain, active_power_offset);
    div_eff = (DIV_W+2)'((energy_divider < DIV_MIN) ? DIV_MIN : energy_divider);
    carry   = 2'sb00;
    e_step  = 2'sb00;
    win_end = 1'b0;
    // Fine accumulation only on the quarter-rate tick
    if (tb.tick_quarter) begin
      next_s.fine = s.fine + delta;
      carry       = lsb_carry(s.fine, next_s.fine);
    end
    // Divider prescaler; carry is at most one LSB per tick by width
    div_sum = s.div_cnt + (DIV_W+2)'(carry);
    if (div_sum >= div_eff) begin
      div_sum = div_sum - div_eff;
      e_step  = 2'sb01;
    end else if (div_sum <= -div_eff) begin
      div_sum = div_sum + div_eff;
      e_step  = -2'sb01;
    end
    next_s.div_cnt = div_sum;
    next_s.energy  = s.energy + ENERGY_W'(e_step);
    // Pulse chain takes the gained carry before the divider
    cf_sum = s.cf_cnt;
    if (carry == 2'sb01) begin
      cf_sum = s.cf_cnt + (CFR_W+1)'(pulse_rate_numerator) + (CFR_W+1)'(1);
    end
    if (s.cf_timer != '0) begin
      next_s.cf_timer = s.cf_timer - 8'h01;
    end else begin
      next_s.cf_out = 1'b0;
    end
    if (cf_sum > (CFR_W+1)'(pulse_rate_denominator)) begin
      // A pulse request during a pulse only restarts its high time
      cf_sum          = cf_sum - (CFR_W+1)'(pulse_rate_denominator) - (CFR_W+1)'(1);
      next_s.cf_out   = 1'b1;
      next_s.cf_timer = CF_PULSE_W'(CF_PULSE_CYC - 1);
    end
    next_s.cf_cnt = cf_sum;
    // Line-cycle window; a mid-cycle start makes the first result short
    next_s.mode_q = line_mode;
    if (!line_mode || !s.mode_q) begin
      next_s.half_cnt = '0;
      next_s.window   = '0;
    end else begin
      next_s.window = s.window + ENERGY_W'(e_step);
      if (half_cycle_edge) begin
        next_s.half_cnt = s.half_cnt + 16'h0001;
        win_end = (s.half_cnt + 16'h0001 >= half_cycle_count);
      end
      if (win_end) begin
        next_s.line_e   = next_s.window;
        next_s.window   = '0;
        next_s.half_cnt = '0;
      end
    end
    // Done flag: a set in the clearing cycle wins
    if (status_clear) begin
      next_s.status = 1'b0;
    end
    if (win_end) begin
      next_s.status = 1'b1;
    end
    next_s.irq_oe_n = !(next_s.status && line_irq_enable);
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s          <= '0;
      s.irq_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_window_end;
    line_mode && s.mode_q && half_cycle_edge && (s.half_cnt + 16'h0001 >= half_cycle_count);
  endsequence
  sequence s_restart;
    s.status && s.half_cnt == '0 && s.window == '0;
  endsequence

  property p_gain_step;
    tb.tick_quarter |=> s.fine - $past(s.fine) ==
      tick_delta($past(active_power), $past(active_power_gain), $past(active_power_offset));
  endproperty
  a_gain_step: assert property (p_gain_step) else $error("gained tick increment wrong");

  property p_offset_only;
    tb.tick_quarter && active_power == '0 |=> s.fine - $past(s.fine) == FINE_W'($past(active_power_offset));
  endproperty
  a_offset_only: assert property (p_offset_only) else $error("offset not added per tick");

  property p_no_tick_hold;
    !tb.tick_quarter |=> $stable(s.fine);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("fine energy moved off tick");

  property p_div_one;
    energy_divider <= DIV_MIN && carry == 2'sb01 |=> s.energy == $past(s.energy) + 24'h000001;
  endproperty
  a_div_one: assert property (p_div_one) else $error("undivided energy missed a step");

  property p_window_irq;
    s_window_end |=> s_restart;
  endproperty
  a_window_irq: assert property (p_window_irq) else $error("window end not flagged");

  // Pin follows the enable sampled at the completing edge, not the one after
  property p_irq_pin;
    s_window_end ##0 line_irq_enable |=> !irq_oe_n;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin not driven low");

  property p_set_wins;
    win_end && status_clear |=> s.status;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a window end");

  property p_line_hold;
    !win_end |=> $stable(s.line_e);
  endproperty
  a_line_hold: assert property (p_line_hold) else $error("line energy changed mid window");

  property p_count_bound;
    line_mode && s.mode_q |-> s.half_cnt < half_cycle_count || half_cycle_count == '0 || $changed(half_cycle_count);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("window ran past half cycle count");

  property p_cf_width;
    $rose(calibration_pulse_out) |-> calibration_pulse_out [*8];
  endproperty
  a_cf_width: assert property (p_cf_width) else $error("calibration pulse too short");
endmodule : active_energy_cal

/* File: dv/host_model.sv */
// Host controller model: sets up line-cycle mode, services the interrupt, reads line energy
`timescale 1ns/1ps
module host_model
  import energy_cal_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire logic                        start,
  input  wire logic [HALF_CYCLE_COUNT_W-1:0]        count_req,
  input  wire logic                        irq_n,
  input  wire logic signed [ENERGY_W-1:0]  line_energy,
  output logic                             line_mode,
  output logic                             line_irq_enable,
  output logic                             status_clear,
  output logic [HALF_CYCLE_COUNT_W-1:0]             half_cycle_count,
  output int                               windows,
  output int                               read_cycle,
  output int                               prev_cycle,
  output logic signed [ENERGY_W-1:0]       read_value
);
  int   cyc = 0;  // Cycle stamp of each read
  logic armed;    // Initial status clear done
  initial begin
    {line_mode, line_irq_enable, status_clear, armed} = 4'h0;
    half_cycle_count = '0;
    {windows, read_cycle, prev_cycle} = '0;
    read_value = '0;
  end
  //////////////////////////////////////////////////////////////////
  // Host drives at the falling edge so the block samples settled values
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    if (rst || !start) begin
      {line_mode, line_irq_enable, status_clear, armed} <= 4'h0;
      windows <= 0;
    end else if (!line_mode) begin
      // Enable mode and interrupt, program count in the same cycle
      line_mode        <= 1'b1;
      line_irq_enable  <= 1'b1;
      half_cycle_count <= count_req;
    end else if (!armed) begin
      status_clear <= 1'b1;
      armed        <= 1'b1;
    end else if (status_clear) begin
      status_clear <= 1'b0;
    end else if (irq_n === 1'b0) begin
      // Read and clear at once, well before the next window ends
      status_clear <= 1'b1;
      windows      <= windows + 1;
      // First result may be short, so it is not recorded
      if (windows > 0) begin
        prev_cycle <= read_cycle;
        read_cycle <= cyc;
        read_value <= line_energy;
      end
    end
  end
endmodule : host_model

/* File: dv/test_active_energy_cal.sv */
// Self-checking bench for the active energy gain/offset block
`timescale 1ns/1ps
module test_active_energy_cal
  import energy_cal_pkg::*;
;
  localparam int H = 200, T = 4096, LIMIT = 80000;  // Half-cycle spacing, run length, hang ceiling
  logic clk_sys = 0, rst = 1, half_cycle_edge = 0, he_on = 0, start = 0, cf_q = 0;
  logic signed [PWR_W-1:0]    active_power = '0;
  logic signed [GAIN_W-1:0]   active_power_gain = '0;
  logic signed [OFS_W-1:0]    active_power_offset = '0;
  logic [DIV_W-1:0]           energy_divider = '0;
  logic [CFR_W-1:0]           pulse_rate_numerator = '0, pulse_rate_denominator = '0;
  logic [HALF_CYCLE_COUNT_W-1:0]       count_req = '0, half_cycle_count;
  logic                       line_mode, line_irq_enable, status_clear, line_done_status;
  logic                       calibration_pulse_out, irq_oe_n;
  logic signed [ENERGY_W-1:0] active_energy_accum, line_accum_active_energy, read_value;
  logic [PERIOD_W-1:0]        line_period;
  int windows, read_cycle, prev_cycle, nm, pulses = 0, cycles = 0, fail_count = 0, check_count = 0, he_cnt = 0;
  wire irq_n = (irq_oe_n === 1'b0) ? 1'b0 : 1'b1;  // Pull-up on the open-drain pin

  active_energy_cal dut (.clk_sys, .rst, .active_power, .half_cycle_edge, .active_power_gain,
    .active_power_offset, .energy_divider, .pulse_rate_numerator, .pulse_rate_denominator,
    .half_cycle_count, .line_mode, .line_irq_enable, .status_clear, .active_energy_accum,
    .line_accum_active_energy, .line_period, .line_done_status, .calibration_pulse_out, .irq_oe_n);
  host_model host (.clk_sys, .rst, .start, .count_req, .irq_n, .line_energy(line_accum_active_energy),
    .line_mode, .line_irq_enable, .status_clear, .half_cycle_count, .windows, .read_cycle,
    .prev_cycle, .read_value);

  //////////////////////////////////////////////////////////////////
  initial forever #50 clk_sys = ~clk_sys;
  // Count rising pulse edges; pulses are spaced wider than their width
  always @(posedge clk_sys) begin
    cf_q <= calibration_pulse_out;
    if (calibration_pulse_out === 1'b1 && cf_q === 1'b0) pulses <= pulses + 1;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fail_count++;
      $display("wrong value at %0t: run hung", $time);
      close_out();
    end
  end
  // Zero-crossing pulses every H cycles while enabled
  always @(negedge clk_sys) begin
    he_cnt <= (he_on && he_cnt < H - 1) ? he_cnt + 1 : 0;
    half_cycle_edge <= he_on && he_cnt == H - 1;
  end

  //////////////////////////////////////////////////////////////////
  task automatic check_near(input logic signed [31:0] act, input longint exp, input int tol, input string what);
    check_count++;
    if ((^act === 1'bx) || act > exp + tol || act < exp - tol) begin
      fail_count++;
      $display("wrong value at %0t: %s got %0d want %0d", $time, what, act, exp);
    end
  endtask : check_near
  task automatic check_bit(input logic act, input logic exp, input string what);
    check_count++;
    if (act !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : check_bit
  task automatic cycles_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cycles_n
  task automatic do_reset;
    rst = 1;
    cycles_n(3);
    check_near(active_energy_accum, 0, 0, "reset energy");
    check_bit(irq_oe_n, 1'b1, "reset irq");
    check_bit(calibration_pulse_out, 1'b0, "reset pulse");
    rst = 0;
    pulses = 0;
  endtask : do_reset
  // Carries over a run: power scaled by gain, moved to 2^-33 units, plus offset
  function automatic longint carries(input longint p, g, o, ticks);
    return (ticks * ((((p * (4096 + g)) >>> GAIN_SHIFT) <<< OFS_FRAC) + o)) >>> FINE_FRAC;
  endfunction : carries
  task automatic energy_run(input longint p, g, o, input int dv, n, d);
    longint c;
    @(negedge clk_sys);
    active_power = p[PWR_W-1:0];
    active_power_gain = g[GAIN_W-1:0];
    active_power_offset = o[OFS_W-1:0];
    energy_divider = dv[DIV_W-1:0];
    pulse_rate_numerator = n[CFR_W-1:0];
    pulse_rate_denominator = d[CFR_W-1:0];
    do_reset();
    cycles_n(T);
    // First tick is taken on the fifth edge after release, so a run holds one tick fewer
    c = carries(p, g, o, T / 4 - 1);
    check_near(active_energy_accum, c / ((dv == 0) ? 1 : dv), 1, "energy");
    check_near(pulses, (c > 0) ? c * (n + 1) / (d + 1) : 0, 1, "pulses");
    $display("energy test done p=%0d g=%0d div=%0d", p, g, dv);
  endtask : energy_run
  task automatic line_run(input int n);
    int w;
    @(negedge clk_sys);
    active_power = 24'h400000;
    {active_power_gain, active_power_offset, energy_divider, pulse_rate_numerator} = '0;
    pulse_rate_denominator = 12'h007;  // Pulse words set before calibration
    do_reset();
    count_req = n[HALF_CYCLE_COUNT_W-1:0];
    he_on = 1;
    start = 1;
    w = 0;
    while (windows < 3 && w < 20000) begin
      cycles_n(1);
      w++;
    end
    check_near(read_cycle - prev_cycle, n * H, 0, "window length");
    check_near(read_value, (longint'(n * H / 4) <<< 30) >>> FINE_FRAC, 1, "line energy");
    check_near(line_period, H / PERIOD_DIV, 1, "period");
    cycles_n(4);
    check_bit(irq_oe_n, 1'b1, "irq released");
    check_bit(line_done_status, 1'b0, "status cleared");
    check_near(line_accum_active_energy, read_value, 0, "line energy held");
    start = 0;
    he_on = 0;
    $display("line test done count=%0d", n);
  endtask : line_run
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  //////////////////////////////////////////////////////////////////
  // Corner cases first, then random gain, offset, divider and pulse words
  initial begin
    void'($urandom(77592));
    energy_run(64'sh3fffff, 2047, 0, 0, 0, 7);
    energy_run(-64'sh400000, -2048, -32768, 0, 0, 7);
    energy_run(64'sh3fffff, 2047, 32767, 4, 1, 15);
    // No power at all: only the offset moves the accumulator, one LSB down
    energy_run(0, 0, -32768, 0, 0, 7);
    repeat (6) begin
      nm = $urandom_range(0, 1);
      energy_run($urandom_range(2097152, 4194303), longint'($urandom_range(0, 4095)) - 2048,
        longint'($urandom_range(0, 65535)) - 32768, $urandom_range(0, 5), nm, 8 * (nm + 1) - 1 + $urandom_range(0, 8));
    end
    line_run(1);
    line_run(3);
    line_run($urandom_range(2, 5));
    close_out();
  end
endmodule : test_active_energy_cal
